// ### rtl/dpsw_ctrl.sv
// Purpose: switch state control register behind a serial port, driving four switch paths
// Assumes: serial mode 0, msb first; sclk at most a quarter of clk_i; frame = command byte + data byte
// Notes:   command byte is read flag then 7-bit address; fault field is sticky until rst_b_i is asserted
// Contract
// - register at 0x20, resets to zero
// - bits 7:6 report fault, zero means none
// - bit 0 closes pole one throw A
// - bit 1 closes pole two throw A
// - bit 2 closes pole two throw B
// - bit 3 closes pole one throw B
// - frame of nine or more bits ending off a byte boundary loads its last four bits into the enables
// - failed power-up configuration sets nonzero fault
`timescale 1ns/10ps
`include "dpsw_params.svh"
module dpsw_ctrl
  import dpsw_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic sclk_i,
  input  wire logic cs_b_i,
  input  wire logic sdi_i,
  input  wire logic cfg_err_i,
  output logic      sdo_o,
  output logic      pole1_throw_a_o,
  output logic      pole2_throw_a_o,
  output logic      pole2_throw_b_o,
  output logic      pole1_throw_b_o
);
  localparam int INIT_CYCLES = (`DPSW_INIT_NS + `DPSW_CLK_PERIOD_NS - 1) / `DPSW_CLK_PERIOD_NS;
  localparam logic [7:0] INIT_LAST = 8'(INIT_CYCLES - 1);

  dpsw_ctrl_st_t s;
  dpsw_ctrl_st_t next_s;
  logic [3:0]    pins_s;
  logic          sclk_s;
  logic          cs_b_s;
  logic          sdi_s;
  logic          cfg_err_s;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          cs_fall;
  logic          cs_rise;
  logic          in_frame;
  logic          run;
  logic [7:0]    cmd_byte;
  logic          short_end;
  logic          write_end;

  // register image as seen by a read
  function automatic logic [7:0] reg_image(input logic [1:0] fault, input logic [3:0] en);
    reg_image = {fault, `DPSW_RSV_VALUE, en};
  endfunction : reg_image

  dpsw_sync #(
    .W (4)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({sclk_i, cs_b_i, sdi_i, cfg_err_i}),
    .q_o     (pins_s)
  );

  assign sclk_s    = pins_s[3];
  assign cs_b_s    = pins_s[2];
  assign sdi_s     = pins_s[1];
  assign cfg_err_s = pins_s[0];
  assign run       = (s.st == DPSW_ST_RUN);
  assign in_frame  = run && !cs_b_s && !s.cs_b_q;
  assign sclk_rise = in_frame && sclk_s && !s.sclk_q;
  assign sclk_fall = in_frame && !sclk_s && s.sclk_q;
  assign cs_fall   = run && !cs_b_s && s.cs_b_q;
  assign cs_rise   = run && cs_b_s && !s.cs_b_q;
  assign cmd_byte  = {s.shift[6:0], sdi_s};
  // frame ends off a byte boundary: last four bits go to the enable field
  assign short_end = cs_rise && (s.cnt >= `DPSW_CMD_BITS) && (s.cnt[2:0] != `DPSW_BYTE_MASK);
  assign write_end = cs_rise && (s.cnt == `DPSW_FRAME_BITS) && !s.shift[`DPSW_RD_FLAG]
                     && (s.shift[14:8] == `DPSW_REG_ADDR);

  always_comb begin
    next_s        = s;
    next_s.sclk_q = sclk_s;
    next_s.cs_b_q = cs_b_s;
    case (s.st)
      DPSW_ST_INIT: begin
        // power-up configuration window; the serial port is deaf here
        if (cfg_err_s) begin
          next_s.fault = `DPSW_FAULT_CFG;
        end
        if (s.init_cnt == INIT_LAST) begin
          next_s.st = DPSW_ST_RUN;
        end else begin
          next_s.init_cnt = s.init_cnt + 8'h01;
        end
      end
      DPSW_ST_RUN: begin
        if (cs_fall) begin
          next_s.cnt  = '0;
          next_s.rdsh = '0;
          next_s.sdo  = 1'b0;
        end
        if (sclk_rise) begin
          next_s.shift = {s.shift[14:0], sdi_s};
          if (s.cnt != `DPSW_CNT_MAX) begin
            next_s.cnt = s.cnt + 5'h01;
          end
          if ((s.cnt == `DPSW_CMD_LAST) && cmd_byte[7] && (cmd_byte[6:0] == `DPSW_REG_ADDR)) begin
            next_s.rdsh = reg_image(s.fault, s.en);
          end
        end
        if (sclk_fall && (s.cnt >= `DPSW_CMD_BITS) && (s.cnt < `DPSW_FRAME_BITS)) begin
          next_s.sdo  = s.rdsh[7];
          next_s.rdsh = {s.rdsh[6:0], 1'b0};
        end
        if (cs_rise) begin
          next_s.sdo = 1'b0;
        end
        // only the enable field is taken; fault and reserved bits are not writable
        if (short_end || write_end) begin
          next_s.en = s.shift[3:0];
        end
      end
      default: begin
        next_s.st = DPSW_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sdo_o           = s.sdo;
  assign pole1_throw_a_o = s.en[0];
  assign pole2_throw_a_o = s.en[1];
  assign pole2_throw_b_o = s.en[2];
  assign pole1_throw_b_o = s.en[3];

  sequence load_seq;
    short_end || write_end;
  endsequence

  sequence init_err_seq;
    (s.st == DPSW_ST_INIT) && cfg_err_s;
  endsequence

  init_open_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s.st == DPSW_ST_INIT) |-> (s.en == `DPSW_EN_RESET))
    else $error("switch path closed before init finished");

  fault_code_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s.fault != `DPSW_FAULT_NONE) |=> (s.fault == $past(s.fault)))
    else $error("fault field changed after being set");

  path1a_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load_seq |=> (pole1_throw_a_o == $past(s.shift[0])))
    else $error("pole one throw A not loaded from bit 0");

  path2a_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load_seq |=> (pole2_throw_a_o == $past(s.shift[1])))
    else $error("pole two throw A not loaded from bit 1");

  path2b_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load_seq |=> (pole2_throw_b_o == $past(s.shift[2])))
    else $error("pole two throw B not loaded from bit 2");

  path1b_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load_seq |=> (pole1_throw_b_o == $past(s.shift[3])))
    else $error("pole one throw B not loaded from bit 3");

  short_frame_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cs_rise && (s.cnt == 5'h09)) |=> (s.en == $past(s.shift[3:0])))
    else $error("odd frame did not load last bits");

  cfg_fault_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    init_err_seq |=> ##[0:2] (s.fault != `DPSW_FAULT_NONE))
    else $error("configuration failure not flagged");

  en_stable_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !$stable(s.en) |-> $past(short_end || write_end))
    else $error("enable bits changed outside a register load");

endmodule : dpsw_ctrl

// ### rtl/dpsw_params.svh
// Purpose: constants of the switch control register and its serial port
// Assumes: 10 MHz core clock
// Notes:   values in one place; logic uses the names only
`ifndef DPSW_PARAMS_SVH
`define DPSW_PARAMS_SVH

`define DPSW_REG_ADDR      7'h20
`define DPSW_REG_RESET     8'h00
`define DPSW_EN_RESET      4'h0
`define DPSW_FAULT_NONE    2'h0
`define DPSW_FAULT_CFG     2'h1
`define DPSW_RSV_VALUE     2'h0
`define DPSW_EN_W          4
`define DPSW_FAULT_W       2
`define DPSW_FRAME_BITS    5'h10
`define DPSW_CMD_BITS      5'h08
`define DPSW_CMD_LAST      5'h07
`define DPSW_CNT_MAX       5'h1f
`define DPSW_BYTE_MASK     3'h0
`define DPSW_RD_FLAG       15
`define DPSW_INIT_NS       10000
`define DPSW_CLK_PERIOD_NS 100

`endif

// ### rtl/dpsw_pkg.sv
// Purpose: types shared by the switch control block
// Assumes: constants come from dpsw_params.svh
// Notes:   state enum is gray along init -> run
package dpsw_pkg;

  typedef enum logic [1:0] {
    DPSW_ST_INIT = 2'h0,
    DPSW_ST_RUN  = 2'h1
  } dpsw_state_t;

  typedef struct packed {
    dpsw_state_t st;
    logic [7:0]  init_cnt;
    logic [1:0]  fault;
    logic [3:0]  en;
    logic        sclk_q;
    logic        cs_b_q;
    logic [15:0] shift;
    logic [4:0]  cnt;
    logic [7:0]  rdsh;
    logic        sdo;
  } dpsw_ctrl_st_t;

endpackage : dpsw_pkg

// ### rtl/dpsw_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module dpsw_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpsw_sync_st_t;

  dpsw_sync_st_t s;
  dpsw_sync_st_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;
endmodule : dpsw_sync

// ### test/dpsw_host.sv
// Purpose: host controller model on the serial port of the switch register
// Assumes: mode 0, msb first; each sclk level held 4 clk_i cycles
// Notes:   sclk stays low outside frames; sdi flips once released
`timescale 1ns/10ps
module dpsw_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      sdi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // n bits of d go out msb first; the last 8 sdo bits come back in r
  task automatic xfer(input int n, input logic [31:0] d, output logic [7:0] r);
    r = 8'h00;
    @(posedge clk_i) cs_b_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= d[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      r = {r[6:0], sdo_i};
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_b_o <= 1'b1;
    sdi_o  <= ~sdi_o;
    repeat (4) @(posedge clk_i);
  endtask : xfer
endmodule : dpsw_host

// ### test/tb.sv
// Purpose: self-checking bench of the switch state control register
// Assumes: host model drives the serial pins
// Notes:   random enables from a fixed seed, corner frames by hand
`timescale 1ns/10ps
module tb;
  logic       clk_i;
  logic       rst_b_i;
  logic       cfg_err_i;
  logic       sclk;
  logic       cs_b;
  logic       sdi;
  logic       sdo;
  logic [3:0] p;
  logic [3:0] en;
  logic [7:0] r;
  int         failures;
  int         checked;
  int         seed;
  int         cyc;

  dpsw_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .sdi_i(sdi),
    .cfg_err_i(cfg_err_i), .sdo_o(sdo), .pole1_throw_a_o(p[0]), .pole2_throw_a_o(p[1]),
    .pole2_throw_b_o(p[2]), .pole1_throw_b_o(p[3]));
  dpsw_host host (.clk_i(clk_i), .sdo_i(sdo), .sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [7:0] rd_exp(input logic [1:0] f, input logic [3:0] e);
    return {f, 2'h0, e};
  endfunction : rd_exp

  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test;
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic do_reset(input logic e);
    @(posedge clk_i);
    rst_b_i   <= 1'b0;
    cfg_err_i <= e;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (110) @(posedge clk_i);
    cfg_err_i <= 1'b0;
  endtask : do_reset

  task automatic wr(input int n, input logic [31:0] d);
    host.xfer(n, d, r);
    repeat (8) @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] e);
    host.xfer(16, 32'h0000a000, r);
    chk(r, e);
  endtask : rd

  initial begin
    seed      = 95;
    rst_b_i   = 1'b0;
    cfg_err_i = 1'b0;
    do_reset(1'b0);
    chk({4'h0, p}, 8'h00);
    rd(rd_exp(2'h0, 4'h0));
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      en = (i == 0) ? 4'hf : 4'($random(seed));
      wr(16, {16'h0000, 8'h20, 4'h0, en});
      chk({4'h0, p}, {4'h0, en});
      rd(rd_exp(2'h0, en));
    end
    $display("enable test done");
    wr(16, {16'h0000, 8'h20, 4'hf, ~en});
    en = ~en;
    rd(rd_exp(2'h0, en));
    wr(16, {16'h0000, 8'h21, 4'h0, ~en});
    chk({4'h0, p}, {4'h0, en});
    wr(12, 32'h0000035c);
    chk({4'h0, p}, 8'h0c);
    wr(8, 32'h000000f3);
    chk({4'h0, p}, 8'h0c);
    // nine clocks: one past a byte boundary, last four bits are 0101
    wr(9, 32'h00000105);
    chk({4'h0, p}, 8'h05);
    $display("frame test done");
    do_reset(1'b1);
    chk({4'h0, p}, 8'h00);
    rd(rd_exp(2'h1, 4'h0));
    wr(16, 32'h00002003);
    rd(rd_exp(2'h1, 4'h3));
    $display("fault test done");
    finish_test;
  end
endmodule : tb
